// ---- hdl/ppcf_regs.vh ----
/*
 * register offsets, field positions and sense codes of the pin port block.
 * assumes byte offsets map to word addresses (index times four).
 */
`ifndef PPCF_REGS_VH
`define PPCF_REGS_VH

`define PPCF_IDX_DIR          6'h00
`define PPCF_IDX_OUT          6'h04
`define PPCF_IDX_TOGGLE       6'h07
`define PPCF_IDX_INPUT        6'h08
`define PPCF_IDX_FLAGS        6'h09
`define PPCF_IDX_PORTCTL      6'h0A
`define PPCF_IDX_SETUP        6'h0B
`define PPCF_IDX_COPYMASK     6'h0C
`define PPCF_IDX_PINCTL_BASE  6'h10
`define PPCF_IDX_PINCTL_LAST  6'h17

`define PPCF_RST_BYTE         8'h00
`define PPCF_SETUP_USED       8'h8F
`define PPCF_BIT_INVERT       7
`define PPCF_BIT_PULL         3
`define PPCF_SENSE_HI         2
`define PPCF_BIT_SLEW         0

`define PPCF_SENSE_OFF        3'h0
`define PPCF_SENSE_ANY        3'h1
`define PPCF_SENSE_RISE       3'h2
`define PPCF_SENSE_FALL       3'h3
`define PPCF_SENSE_NOBUF      3'h4
`define PPCF_SENSE_LOW        3'h5

`define PPCF_HTRANS_NONSEQ    2'h2
`define PPCF_HTRANS_SEQ       2'h3

`endif

// ---- hdl/ppcf_pin_sense.v ----
/*
 * per-pin input sampling and event detection for one pin.
 * assumes pin_in is synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ppcf_regs.vh"

module ppcf_pin_sense (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       clk_en,
    input  wire       pin_in,
    input  wire [7:0] pin_ctl,
    output wire       buf_on,
    output reg        level_reg,
    output reg        event_hit
);

    wire [2:0] sense;
    wire       seen;
    reg        prev_reg;

    assign sense = pin_ctl[`PPCF_SENSE_HI:0];
    // RL13 buffer off code
    assign buf_on = (sense != `PPCF_SENSE_NOBUF);
    // RL10 input inversion
    assign seen = pin_in ^ pin_ctl[`PPCF_BIT_INVERT];

    // RL3 RL4 sample when buffer on
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else if (clk_en && buf_on) begin
            level_reg <= seen;
            prev_reg  <= seen;
        end
    end

    // RL12 RL13 RL14 sense decode
    always @* begin
        case (sense)
            `PPCF_SENSE_ANY:  event_hit = buf_on && (seen != prev_reg);
            `PPCF_SENSE_RISE: event_hit = seen && !prev_reg;
            `PPCF_SENSE_FALL: event_hit = !seen && prev_reg;
            `PPCF_SENSE_LOW:  event_hit = !seen;
            default:          event_hit = 1'b0;
        endcase
    end

endmodule // ppcf_pin_sense

`default_nettype wire

// ---- hdl/ppcf_port.v ----
/*
 * eight-pin port: output latch, input level, event flags, slew control,
 * shared setup value and copy mask, per-pin control, ahb-lite slave.
 * assumes a single ahb-lite master, word accesses, pins synchronous.
 */
// What this block does
// RL1: writing one to toggle or input register inverts that output bit
// RL2: toggle register reads back the output latch
// RL3: input bit holds sampled pin level while buffer enabled
// RL4: disabled buffer stops sampling, input bit keeps its value
// RL5: flag sets when pin change or level matches its sense setting
// RL6: writing one clears a flag, zero leaves it
// RL7: port control bit 0 enables slew limiting on all pins
// RL8: setup value is one shared copy across all ports
// RL9: setup holds invert bit 7, pull bit 3, sense bits 2:0
// RL10: invert enable inverts both driven and sampled pin value
// RL11: pull-up enabled only while pin is input-only
// RL12: sense 1 both edges, 2 rising, 3 falling, buffer on
// RL13: sense 0 no flag buffer on, 4 both off, 6,7 reserved
// RL14: sense 5 flags low level, repeatedly while low
// RL15: copy mask bit one copies setup value into that pin control
// RL16: copy mask reads as zero
// RL17: all selected pin controls update in the same cycle
// RL18: software writes setup value first, then copy mask
// RL19: pin controls at 0x10 plus index, setup layout, reset zero
// RL20: latch drives pin level only while direction enables driver
// RL21: flag set wins over simultaneous software clear
`timescale 1ns/10ps
`default_nettype none
`include "ppcf_regs.vh"

module ppcf_port (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire [7:0]  shared_setup_in,
    output wire        shared_setup_we,
    output wire [7:0]  shared_setup_wdata,
    input  wire [7:0]  pin_in,
    output wire [7:0]  pin_out,
    output wire [7:0]  pin_oe,
    output wire [7:0]  pull_enable,
    output wire [7:0]  input_buffer_enable,
    output wire        slew_limit_enable
);

    ////////////////////////////////////////////////////////////////////
    // bus address phase capture

    reg        wr_pend_reg;
    reg [5:0]  wr_idx_reg;
    reg [7:0]  dir_reg;
    reg [7:0]  out_reg;
    reg [7:0]  flags_reg;
    reg [7:0]  portctl_reg;
    reg [63:0] pinctl_reg;
    reg [63:0] pinctl_next;
    reg [7:0]  flags_next;
    reg [7:0]  out_next;
    reg [31:0] rd_next;
    wire [7:0] level;
    wire [7:0] hit;
    wire [7:0] wbyte;
    wire       addr_ok;
    wire       take;
    wire [5:0] a_idx;
    integer    i;

    function is_reg;
        input [5:0] idx;
        begin
            is_reg = (idx == `PPCF_IDX_DIR) || (idx == `PPCF_IDX_OUT) ||
                     (idx == `PPCF_IDX_TOGGLE) || (idx == `PPCF_IDX_INPUT) ||
                     (idx == `PPCF_IDX_FLAGS) || (idx == `PPCF_IDX_PORTCTL) ||
                     (idx == `PPCF_IDX_SETUP) || (idx == `PPCF_IDX_COPYMASK) ||
                     ((idx >= `PPCF_IDX_PINCTL_BASE) &&
                      (idx <= `PPCF_IDX_PINCTL_LAST));
        end
    endfunction

    function [7:0] pin_ctl;
        input [63:0] all;
        input [2:0]  n;
        begin
            pin_ctl = all[n*8 +: 8];
        end
    endfunction

    assign a_idx     = haddr[7:2];
    assign addr_ok   = (haddr[31:8] == 24'h000000) && is_reg(a_idx);
    assign take      = hsel && hready && clk_en &&
                       ((htrans == `PPCF_HTRANS_NONSEQ) ||
                        (htrans == `PPCF_HTRANS_SEQ));
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wbyte     = hwdata[7:0];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= `PPCF_IDX_DIR;
        end else if (clk_en) begin
            wr_pend_reg <= take && hwrite && addr_ok;
            wr_idx_reg  <= a_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-pin sense

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            ppcf_pin_sense u_sense (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .clk_en    (clk_en),
                .pin_in    (pin_in[g]),
                .pin_ctl   (pinctl_reg[g*8 +: 8]),
                .buf_on    (input_buffer_enable[g]),
                .level_reg (level[g]),
                .event_hit (hit[g])
            );
            // RL10 output inversion
            // RL20 drive only when direction set
            assign pin_out[g] = out_reg[g] ^
                                pinctl_reg[g*8 + `PPCF_BIT_INVERT];
            assign pin_oe[g]  = dir_reg[g];
            // RL11 pull only when input-only
            assign pull_enable[g] = pinctl_reg[g*8 + `PPCF_BIT_PULL] &&
                                    !dir_reg[g];
        end
    endgenerate

    // RL7 port-wide slew limit
    assign slew_limit_enable = portctl_reg[`PPCF_BIT_SLEW];

    // RL8 shared setup write out
    assign shared_setup_we    = clk_en && wr_pend_reg &&
                                (wr_idx_reg == `PPCF_IDX_SETUP);
    // RL9 unused bits dropped
    assign shared_setup_wdata = wbyte & `PPCF_SETUP_USED;

    ////////////////////////////////////////////////////////////////////
    // register next values

    always @* begin
        out_next    = out_reg;
        pinctl_next = pinctl_reg;
        // RL6 write one clears
        flags_next  = flags_reg;
        if (wr_pend_reg && (wr_idx_reg == `PPCF_IDX_FLAGS))
            flags_next = flags_reg & ~wbyte;
        // RL5 RL21 set wins over clear
        flags_next = flags_next | hit;
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                `PPCF_IDX_OUT: out_next = wbyte;
                // RL1 toggle by either register
                `PPCF_IDX_TOGGLE,
                `PPCF_IDX_INPUT: out_next = out_reg ^ wbyte;
                // RL15 RL17 parallel copy
                `PPCF_IDX_COPYMASK: begin
                    for (i = 0; i < 8; i = i + 1) begin
                        if (wbyte[i])
                            pinctl_next[i*8 +: 8] = shared_setup_in;
                    end
                end
                default: ;
            endcase
            // RL19 individual pin control
            if ((wr_idx_reg >= `PPCF_IDX_PINCTL_BASE) &&
                (wr_idx_reg <= `PPCF_IDX_PINCTL_LAST))
                pinctl_next[wr_idx_reg[2:0]*8 +: 8] =
                    wbyte & `PPCF_SETUP_USED;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_reg     <= `PPCF_RST_BYTE;
            out_reg     <= `PPCF_RST_BYTE;
            flags_reg   <= `PPCF_RST_BYTE;
            portctl_reg <= `PPCF_RST_BYTE;
            pinctl_reg  <= {8{`PPCF_RST_BYTE}};
        end else if (clk_en) begin
            out_reg    <= out_next;
            flags_reg  <= flags_next;
            pinctl_reg <= pinctl_next;
            if (wr_pend_reg && (wr_idx_reg == `PPCF_IDX_DIR))
                dir_reg <= wbyte;
            if (wr_pend_reg && (wr_idx_reg == `PPCF_IDX_PORTCTL))
                portctl_reg <= {7'h00, wbyte[`PPCF_BIT_SLEW]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data

    always @* begin
        rd_next = 32'h00000000;
        case (a_idx)
            `PPCF_IDX_DIR:     rd_next[7:0] = dir_reg;
            `PPCF_IDX_OUT:     rd_next[7:0] = out_reg;
            // RL2 toggle reads latch
            `PPCF_IDX_TOGGLE:  rd_next[7:0] = out_reg;
            `PPCF_IDX_INPUT:   rd_next[7:0] = level;
            `PPCF_IDX_FLAGS:   rd_next[7:0] = flags_reg;
            `PPCF_IDX_PORTCTL: rd_next[7:0] = portctl_reg;
            `PPCF_IDX_SETUP:   rd_next[7:0] = shared_setup_in;
            // RL16 mask reads zero
            `PPCF_IDX_COPYMASK: rd_next[7:0] = `PPCF_RST_BYTE;
            default: begin
                if (addr_ok)
                    rd_next[7:0] = pin_ctl(pinctl_reg, a_idx[2:0]);
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (clk_en && take && !hwrite)
            hrdata <= rd_next;
    end

endmodule // ppcf_port

`default_nettype wire

// ---- bench/ppcf_port_properties.sv ----
/* assertions on the bus and pin outputs of ppcf_port.
   bound into every ppcf_port; assumes one bus master. */
`timescale 1ns/10ps
`default_nettype none
module ppcf_port_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        shared_setup_we,
    input wire logic [7:0]  shared_setup_wdata,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pull_enable,
    input wire logic        slew_limit_enable
);
    logic        wr_q;
    logic        rd_q;
    logic [31:0] a_q;
    wire         take = hsel & hready & htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q  <= 32'h0;
        end else begin
            wr_q <= take & hwrite;
            rd_q <= take & !hwrite;
            a_q  <= haddr;
        end
    end
////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_toggle_inverts: assert property (
        wr_q && (a_q == 32'h1C || a_q == 32'h20) |=>
        pin_out == ($past(pin_out) ^ $past(hwdata[7:0])))
        else $error("toggle write did not invert latch");
    a_slew_write: assert property (
        wr_q && a_q == 32'h28 |=> slew_limit_enable == $past(hwdata[0]))
        else $error("slew bit not written");
    a_slew_holds: assert property (
        !(wr_q && a_q == 32'h28) |=> $stable(slew_limit_enable))
        else $error("slew bit changed without write");
    a_pull_gate: assert property ((pull_enable & pin_oe) == 8'h00)
        else $error("pull-up on an output pin");
    a_setup_strobe: assert property (
        shared_setup_we == (wr_q && a_q == 32'h2C))
        else $error("setup strobe wrong");
    a_setup_fields: assert property (
        shared_setup_we |-> shared_setup_wdata == (hwdata[7:0] & 8'h8F))
        else $error("setup data fields wrong");
    a_copy_reads_zero: assert property (
        rd_q && a_q == 32'h30 |-> hrdata == 32'h0)
        else $error("copy mask read not zero");
    a_dir_drives: assert property (
        wr_q && a_q == 32'h0 |=> pin_oe == $past(hwdata[7:0]))
        else $error("driver enable not from direction");
    c_copy: cover property (wr_q && a_q == 32'h30);
    c_toggle: cover property (wr_q && a_q == 32'h1C);
    c_pull: cover property (pull_enable != 8'h00);
endmodule // ppcf_port_chk
bind ppcf_port ppcf_port_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .shared_setup_we(shared_setup_we), .pin_out(pin_out),
    .shared_setup_wdata(shared_setup_wdata), .pin_oe(pin_oe),
    .pull_enable(pull_enable), .slew_limit_enable(slew_limit_enable));
`default_nettype wire

// ---- bench/ppcf_pin_model.sv ----
/* pins outside the port and the shared setup register.
   assumes external levels change just after hclk edges. */
`timescale 1ns/10ps
`default_nettype none
module ppcf_pin_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] drv_val,
    input  wire logic       setup_we,
    input  wire logic [7:0] setup_wdata,
    output logic      [7:0] pin_in,
    output logic      [7:0] setup_q
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) setup_q <= 8'h00;
        else if (setup_we) setup_q <= setup_wdata;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_val);
endmodule // ppcf_pin_model
`default_nettype wire

// ---- bench/ppcf_port_tb_top.sv ----
/* self-checking bench for ppcf_port over ahb-lite.
   assumes single transfers and hreadyout as hready. */
`timescale 1ns/10ps
`default_nettype none
module ppcf_port_tb_top;
    logic        hclk, hresetn, hsel, hwrite, rd_dp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata;
    logic [7:0]  drv_val, out_e, t;
    logic [7:0]  q[$];
    wire         hreadyout, hresp, setup_we, slew;
    wire  [31:0] hrdata;
    wire  [7:0]  setup_wdata, setup_q, pin_in, pin_out;
    wire  [7:0]  pin_oe, pull_en, buf_en;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;
    int          c;
    integer      seed = 32'h9A93;
    ppcf_port uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .shared_setup_in(setup_q), .shared_setup_we(setup_we),
        .shared_setup_wdata(setup_wdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_enable(pull_en),
        .input_buffer_enable(buf_en), .slew_limit_enable(slew));
    ppcf_pin_model pins (.hclk(hclk), .hresetn(hresetn),
        .pin_out(pin_out), .pin_oe(pin_oe), .drv_val(drv_val),
        .setup_we(setup_we), .setup_wdata(setup_wdata),
        .pin_in(pin_in), .setup_q(setup_q));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e, input string n);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd_dp <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_dp <= 1'b0;
    endtask
    task rd(input logic [31:0] a, input logic [7:0] e);
        q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    always @(posedge hclk) begin
        if (rd_dp === 1'b1) chk(hrdata, {24'h0, q.pop_front()}, "hrdata");
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        {hresetn, hsel, hwrite, rd_dp, htrans, haddr, hwdata} = 0;
        drv_val = 8'h00;
        out_e = 8'h00;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        for (c = 7; c < 24; c++) rd(c * 4, 8'h00);
        bus(1'b1, 32'h0, 8'hFF);
        for (c = 0; c < 6; c++) begin
            t = $random(seed);
            out_e = out_e ^ t;
            bus(1'b1, c[0] ? 32'h20 : 32'h1C, t);
        end
        rd(32'h1C, out_e);
        chk(pin_out, out_e, "pin_out");
        rd(32'h20, out_e);
        bus(1'b1, 32'h28, 8'h01);
        @(posedge hclk);
        chk(slew, 1, "slew");
        rd(32'h28, 8'h01);
        bus(1'b1, 32'h0, 8'h00);
        for (c = 0; c < 6; c++) begin
            bus(1'b1, 32'h2C, 8'h08 | c[7:0]);
            bus(1'b1, 32'h30, 8'h02);
            bus(1'b1, 32'h24, 8'hFF);
            chk(pull_en, 8'h02, "pull");
            chk(buf_en[1], c != 4, "buf");
            rd(32'h44, 8'h08 | c[7:0]);
            rd(32'h24, c == 5 ? 8'h02 : 8'h00);
            drv_val <= 8'h02;
            repeat (4) @(posedge hclk);
            rd(32'h24, (c == 1 || c == 2 || c == 5) ? 8'h02 : 8'h00);
            rd(32'h20, c == 4 ? 8'h00 : 8'h02);
            bus(1'b1, 32'h24, 8'hFF);
            drv_val <= 8'h00;
            repeat (4) @(posedge hclk);
            rd(32'h24, (c == 1 || c == 3 || c == 5) ? 8'h02 : 8'h00);
        end
        bus(1'b1, 32'h2C, 8'hFF);
        rd(32'h2C, 8'h8F);
        bus(1'b1, 32'h2C, 8'h80);
        bus(1'b1, 32'h30, 8'hF0);
        repeat (2) @(posedge hclk);
        chk(pin_out, out_e ^ 8'hF0, "pin_out");
        rd(32'h20, 8'hF0);
        rd(32'h50, 8'h80);
        rd(32'h5C, 8'h80);
        rd(32'h30, 8'h00);
        bus(1'b1, 32'h34, 8'hFF);
        rd(32'h34, 8'h00);
        repeat (2) @(posedge hclk);
        complete_run;
    end
endmodule // ppcf_port_tb_top
`default_nettype wire
